/* File: bench/reset_and_interrupt_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module reset_and_interrupt_control_tb;
	// shortened release counts
	localparam int         REL_HW = 300;
	localparam int         REF_HW = 200;
	localparam int         REL_SW = 100;
	localparam int         REF_SW = 150;
	localparam logic [7:0] P1     = rsic_pkg::A_PHY1_BASE;
	localparam logic [7:0] P2     = rsic_pkg::A_PHY2_BASE;
	localparam logic [7:0] SA     = rsic_pkg::A_SW_STAT_A;
	localparam logic [7:0] SB     = rsic_pkg::A_SW_STAT_B;
	localparam logic [7:0] MA     = rsic_pkg::A_SW_MASK_A;
	localparam logic [7:0] MB     = rsic_pkg::A_SW_MASK_B;
	// stimulus and observed signals
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0]  sw_evt_a = 8'h0;
	logic [7:0]  sw_evt_b = 8'h0;
	logic [3:0]  phy1_evt = 4'h0;
	logic [3:0]  phy2_evt = 4'h0;
	logic [3:0]  phy1_err = 4'h0;
	logic [3:0]  phy2_err = 4'h0;
	logic [1:0]  phy_powered_down = 2'h0;
	wire logic   hreadyout, reset_pin_n, power_good, irq_n, chip_rst_n, io_tristate;
	wire logic   ref_clock_out_en, phy2_rst_n, mac_rst_n, tx_abort;
	wire logic   phy1_rst_n, cfg_latch, osc_en, pll_en, hresp;
	wire logic [31:0] hrdata;
	logic [31:0] q, rnd, m;
	int          fail_count = 0, checked = 0, cyc = 0, lo_mac = 0, lo_p2 = 0, n_ab = 0, i, k, b;
	int          lo_p1 = 0, n_cl = 0;

	rsic_reset_irq #(.REL_HW_CYC(REL_HW), .REF_HW_CYC(REF_HW), .REL_SW_CYC(REL_SW), .REF_SW_CYC(REF_SW),
		.OSC_CYC(20)) i_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(rsic_pkg::HSIZE_WORD), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .reset_pin_n, .power_good, .sw_evt_a, .sw_evt_b,
		.phy1_evt, .phy2_evt, .phy1_err, .phy2_err, .phy_powered_down, .irq_n, .chip_rst_n, .io_tristate,
		.cfg_latch, .osc_en, .pll_en, .ref_clock_out_en, .phy1_rst_n, .phy2_rst_n, .mac_rst_n, .tx_abort
	);
	rsic_host_pins i_host (.hclk, .reset_pin_n, .power_good);

	// 100 MHz clock
	always #5 hclk = ~hclk;

	// reset output low-cycle counters, abort and latch high-cycle counters, and hang guard
	always @(posedge hclk) begin
		cyc++;
		lo_mac += (mac_rst_n === 1'b0);
		lo_p2 += (phy2_rst_n === 1'b0);
		lo_p1 += (phy1_rst_n === 1'b0);
		n_ab += (tx_abort === 1'b1);
		n_cl += (cfg_latch === 1'b1);
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one single word transfer, address phase then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask

	// distance between internal release and reference clock enable
	task release_chk(input int d);
		int tc;
		int tr;
		tc = -1;
		tr = -1;
		for (int j = 0; j < 3000 && (tc < 0 || tr < 0); j++) begin
			@(posedge hclk);
			if (tr < 0 && ref_clock_out_en === 1'b1) tr = j;
			if (tc < 0 && chip_rst_n === 1'b1) tc = j;
		end
		chk(32'(tc - tr), 32'(d));
		chk(32'(io_tristate), 32'h0);
		chk(32'({hresp, osc_en, pll_en}), 32'h3);
	endtask

	task close_out();
		$display("mismatches %0d of %0d checks", fail_count, checked);
		if (fail_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		rnd = 32'hA0C6E111;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		release_chk(REL_HW + 1 - REF_HW);
		bus(0, P1 + rsic_pkg::O_SYS_FLG, 0);
		chk(q, 32'h1);
		bus(0, P1 + rsic_pkg::O_STATE, 0);
		chk(q & 32'h1, 32'h1);
		bus(0, SA, 0);
		chk(q, 32'h100);
		bus(0, SB, 0);
		chk(q, 32'h100);
		bus(0, 8'hFC, 0);
		chk(q, 32'h0);
		bus(0, MA, 0);
		chk(q, 32'(rsic_pkg::MASK_RST));
		// source flags first, then the summary bits
		bus(1, P1 + rsic_pkg::O_SYS_FLG, 1);
		bus(1, P2 + rsic_pkg::O_SYS_FLG, 1);
		bus(1, SA, 32'h100);
		bus(1, SB, 32'h100);
		// random masks against single switch events
		for (i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			k = rnd[2:0];
			m = 32'(rnd[15:8]);
			bus(1, rnd[16] ? MB : MA, m);
			sw_evt_a <= rnd[16] ? 8'h0 : 8'h1 << k;
			sw_evt_b <= rnd[16] ? 8'h1 << k : 8'h0;
			@(posedge hclk);
			sw_evt_a <= 8'h0;
			sw_evt_b <= 8'h0;
			repeat (2) @(posedge hclk);
			chk(32'(irq_n), 32'(!m[k]));
			bus(0, rnd[16] ? SB : SA, 0);
			chk(q, 32'h1 << k);
			bus(1, rnd[16] ? SB : SA, 32'h1 << k);
			repeat (2) @(posedge hclk);
			chk(32'(irq_n), 32'h1);
		end
		// phy conditions recorded only when enabled
		rnd = lfsr(rnd);
		bus(1, P1 + rsic_pkg::O_BLK_EN, 32'(rnd[3:0]));
		bus(1, P2 + rsic_pkg::O_BLK_EN, 32'(rnd[7:4]));
		phy1_evt <= 4'hF;
		phy2_evt <= 4'hF;
		@(posedge hclk);
		phy1_evt <= 4'h0;
		phy2_evt <= 4'h0;
		bus(0, P1 + rsic_pkg::O_BLK_FLG, 0);
		chk(q, 32'(rnd[3:0]));
		bus(0, P2 + rsic_pkg::O_BLK_FLG, 0);
		chk(q, 32'(rnd[7:4]));
		bus(1, P1 + rsic_pkg::O_BLK_FLG, 32'hF);
		bus(1, SA, 32'h100);
		bus(1, MA, 32'h100);
		repeat (2) @(posedge hclk);
		chk(32'(irq_n), 32'h1);
		// software request through the first phy
		bus(1, P1 + rsic_pkg::O_SYS_EN, 32'h3);
		repeat (4) @(posedge hclk);
		chk(32'(irq_n), 32'h0);
		bus(0, P1 + rsic_pkg::O_SYS_FLG, 0);
		chk(q & 32'h2, 32'h2);
		// sticky system errors
		bus(1, P2 + rsic_pkg::O_SYS_EN, 32'hF1);
		phy2_err <= 4'h5;
		phy1_err <= 4'h5;
		@(posedge hclk);
		phy2_err <= 4'h0;
		phy1_err <= 4'h0;
		bus(1, P2 + rsic_pkg::O_SYS_FLG, 32'hF0);
		bus(0, P2 + rsic_pkg::O_SYS_FLG, 0);
		chk(q & 32'hF0, 32'h50);
		bus(0, P1 + rsic_pkg::O_SYS_FLG, 0);
		chk(q & 32'hF0, 32'h50);
		// phy block reset pulse and self clear
		b = lo_p2;
		k = lo_p1;
		bus(1, rsic_pkg::A_BLK_RST, 32'h3);
		repeat (200) @(posedge hclk);
		chk(32'(lo_p2 - b), 32'(rsic_pkg::SUB_RST_CYC));
		chk(32'(lo_p1 - k), 32'(rsic_pkg::SUB_RST_CYC));
		bus(0, rsic_pkg::A_BLK_RST, 0);
		chk(q, 32'h0);
		bus(0, P2 + rsic_pkg::O_SYS_EN, 0);
		chk(q, 32'hF1);
		// keyed mac reset, first with phy1 powered down
		for (i = 0; i < 2; i++) begin
			phy_powered_down <= i ? 2'b00 : 2'b01;
			b = lo_mac;
			bus(1, rsic_pkg::A_MAC_RST, rsic_pkg::MAC_KEY1);
			bus(1, rsic_pkg::A_MAC_RST, rsic_pkg::MAC_KEY2);
			repeat (200) @(posedge hclk);
			chk(32'(lo_mac - b), i ? 32'(rsic_pkg::SUB_RST_CYC) : 32'd0);
		end
		// chip soft reset spares the second phy
		b = lo_p2;
		k = n_ab;
		bus(1, rsic_pkg::A_SOFT_RST, 32'h1);
		repeat (2) @(posedge hclk);
		release_chk(REL_SW + 1 - REF_SW);
		chk(32'(n_ab - k), 32'h1);
		chk(32'(lo_p2 - b), 32'h0);
		bus(0, MA, 0);
		chk(q, 32'h0);
		bus(0, P2 + rsic_pkg::O_SYS_EN, 0);
		chk(q, 32'hF1);
		// reset pin glitch, then a real hardware reset
		i_host.pulse(50);
		repeat (10) @(posedge hclk);
		chk(32'(chip_rst_n), 32'h1);
		i_host.pulse(1000);
		chk(32'(ref_clock_out_en), 32'h0);
		release_chk(REL_HW + 1 - REF_HW);
		bus(0, P2 + rsic_pkg::O_SYS_FLG, 0);
		chk(q & 32'hF0, 32'h0);
		// power not good holds the chip in reset
		i_host.pg_dip(20);
		chk(32'(chip_rst_n), 32'h0);
		release_chk(REL_HW + 1 - REF_HW);
		chk(32'(n_cl), 32'd4);
		close_out();
	end
endmodule
`default_nettype wire

/* File: bench/rsic_host_pins.sv */
`timescale 1ns/100ps
`default_nettype none
module rsic_host_pins (
	// clock
	input  wire logic hclk,
	// pins driven by the host
	output logic      reset_pin_n,
	output logic      power_good
);
	// both pins rest high until the host acts
	initial begin
		reset_pin_n = 1'b1;
		power_good  = 1'b1;
	end
	// hold the reset pin low for n cycles; short values make a glitch
	task pulse(input int n);
		reset_pin_n <= 1'b0;
		repeat (n) @(posedge hclk);
		reset_pin_n <= 1'b1;
	endtask
	// supply dip seen as power not good
	task pg_dip(input int n);
		power_good <= 1'b0;
		repeat (n) @(posedge hclk);
		power_good <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: src/rsic_pkg.sv */
package rsic_pkg;

	// clock and times as printed
	localparam int CLK_MHZ       = 100;
	localparam int T_REL_HW_MS   = 90;
	localparam int T_REF_HW_MS   = 70;
	localparam int T_REL_SW_MS   = 10;
	localparam int T_REF_SW_MS   = 25;
	localparam int T_OSC_US      = 500;
	localparam int T_GLITCH_US   = 1;
	localparam int T_SUB_RST_NS  = 1200;

	// derived cycle counts (exact at 100 MHz)
	localparam int REL_HW_CYC    = T_REL_HW_MS * 1000 * CLK_MHZ;
	localparam int REF_HW_CYC    = T_REF_HW_MS * 1000 * CLK_MHZ;
	localparam int REL_SW_CYC    = T_REL_SW_MS * 1000 * CLK_MHZ;
	localparam int REF_SW_CYC    = T_REF_SW_MS * 1000 * CLK_MHZ;
	localparam int OSC_CYC       = T_OSC_US * CLK_MHZ;
	localparam int GLITCH_CYC    = (T_GLITCH_US * CLK_MHZ + 0) > 0 ? T_GLITCH_US * CLK_MHZ : 1;
	localparam int SUB_RST_CYC   = T_SUB_RST_NS * CLK_MHZ / 1000;
	localparam int CNT_W         = 24;

	// register byte offsets
	localparam logic [7:0] A_SW_STAT_A = 8'h00;
	localparam logic [7:0] A_SW_STAT_B = 8'h04;
	localparam logic [7:0] A_SW_MASK_A = 8'h08;
	localparam logic [7:0] A_SW_MASK_B = 8'h0C;
	localparam logic [7:0] A_SOFT_RST  = 8'h10;
	localparam logic [7:0] A_BLK_RST   = 8'h14;
	localparam logic [7:0] A_MAC_RST   = 8'h18;
	localparam logic [7:0] A_PHY1_BASE = 8'h20;
	localparam logic [7:0] A_PHY2_BASE = 8'h40;
	localparam logic [7:0] O_BLK_EN    = 8'h00;
	localparam logic [7:0] O_BLK_FLG   = 8'h04;
	localparam logic [7:0] O_SYS_EN    = 8'h08;
	localparam logic [7:0] O_SYS_FLG   = 8'h0C;
	localparam logic [7:0] O_STATE     = 8'h10;

	// field layout
	localparam int STAT_W      = 9;
	localparam int STAT_PHY    = 8;
	localparam int BLK_W       = 4;
	localparam int SYS_W       = 8;
	localparam int SYS_HW      = 0;
	localparam int SYS_SW      = 1;
	localparam int SYS_ERR_LSB = 4;
	localparam int ST_RDY      = 0;
	localparam int ST_PD       = 1;

	// reset values
	localparam logic [8:0] MASK_RST   = 9'h000;
	localparam logic [3:0] BLK_EN_RST = 4'h0;
	localparam logic [7:0] SYS_EN_RST = 8'h01;

	// bus and keys (key values arbitrary)
	localparam logic [2:0]  HSIZE_WORD = 3'h2;
	localparam logic [31:0] MAC_KEY1   = 32'h0000A5A5;
	localparam logic [31:0] MAC_KEY2   = 32'h00005A5A;

	typedef enum logic [2:0] {ST_HOLD, ST_TRI, ST_LATCH, ST_OSC, ST_PLL, ST_RUN} rsic_state_t;

endpackage

/* File: src/rsic_reset_irq.sv */
// Behaviour
// - masked switch event drives interrupt low
// - four phy conditions gated by enable
// - phy flags record enabled conditions
// - hardware reset latches enabled reset interrupt
// - phy interrupt sets its switch status flag
// - software request latches and raises interrupt
// - system error flags sticky until hardware reset, or soft reset for phy1
// - held in reset until power good
// - low pulses under one microsecond ignored
// - release sequence, registers ready within 90 ms
// - reference clock low until 70 ms
// - soft reset spares second phy
// - soft reset aborts transmission immediately
// - soft reset sequence ready within 10 ms
// - per phy system ready flag
// - reference clock low 25 ms after soft
// - phy block reset 1.2 us, self clears
// - keyed mac reset for 1.2 us
// - mac reset only with phy1 powered up
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none

module rsic_reset_irq #(
	parameter int REL_HW_CYC = rsic_pkg::REL_HW_CYC,
	parameter int REF_HW_CYC = rsic_pkg::REF_HW_CYC,
	parameter int REL_SW_CYC = rsic_pkg::REL_SW_CYC,
	parameter int REF_SW_CYC = rsic_pkg::REF_SW_CYC,
	parameter int OSC_CYC    = rsic_pkg::OSC_CYC
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// pins
	input  wire logic        reset_pin_n,
	input  wire logic        power_good,
	// event sources
	input  wire logic [7:0]  sw_evt_a,
	input  wire logic [7:0]  sw_evt_b,
	input  wire logic [3:0]  phy1_evt,
	input  wire logic [3:0]  phy2_evt,
	input  wire logic [3:0]  phy1_err,
	input  wire logic [3:0]  phy2_err,
	input  wire logic [1:0]  phy_powered_down,
	// interrupt and reset outputs
	output logic             irq_n,
	output logic             chip_rst_n,
	output logic             io_tristate,
	output logic             cfg_latch,
	output logic             osc_en,
	output logic             pll_en,
	output logic             ref_clock_out_en,
	output logic             phy1_rst_n,
	output logic             phy2_rst_n,
	output logic             mac_rst_n,
	output logic             tx_abort
);

	localparam int         CW    = rsic_pkg::CNT_W;
	localparam logic [7:0] GL_M1 = 8'(rsic_pkg::GLITCH_CYC - 1);
	localparam logic [7:0] SUB_M1 = 8'(rsic_pkg::SUB_RST_CYC - 1);

	function automatic logic [7:0] phy_off(input int i, input logic [7:0] sub);
		phy_off = (i == 0 ? rsic_pkg::A_PHY1_BASE : rsic_pkg::A_PHY2_BASE) + sub;
	endfunction

	// pin synchronisers; a change counts once stages two and three agree
	logic [2:0] rst_s_r;
	logic [2:0] pwr_s_r;
	logic       rst_lvl_r;
	logic       pwr_lvl_r;
	logic [7:0] glitch_cnt_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_s_r      <= 3'h0;
			pwr_s_r      <= 3'h0;
			rst_lvl_r    <= 1'b0;
			pwr_lvl_r    <= 1'b0;
			glitch_cnt_r <= 8'h00;
		end else begin
			rst_s_r <= {rst_s_r[1:0], reset_pin_n};
			pwr_s_r <= {pwr_s_r[1:0], power_good};
			if (rst_s_r[1] == rst_s_r[2]) begin
				rst_lvl_r <= rst_s_r[2];
			end
			if (pwr_s_r[1] == pwr_s_r[2]) begin
				pwr_lvl_r <= pwr_s_r[2];
			end
			if (rst_lvl_r) begin
				glitch_cnt_r <= 8'h00;
			end else if (glitch_cnt_r != GL_M1) begin
				glitch_cnt_r <= glitch_cnt_r + 8'h01;
			end
		end
	end

	// deglitched reset request and power supervision
	wire rst_low_ok = !rst_lvl_r && (glitch_cnt_r == GL_M1);
	wire hw_req     = !pwr_lvl_r || rst_low_ok;

	// ahb-lite address phase capture; reads take one wait state
	logic       wr_pend_r;
	logic       rd_pend_r;
	logic       map_ok_r;
	logic [7:0] dp_addr_r;
	logic       hreadyout_r;
	logic [31:0] hrdata_r;
	wire        acc = hsel && htrans[1] && hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			map_ok_r    <= 1'b0;
			dp_addr_r   <= 8'h00;
			hreadyout_r <= 1'b1;
		end else begin
			wr_pend_r   <= acc && hwrite;
			rd_pend_r   <= acc && !hwrite;
			hreadyout_r <= !(acc && !hwrite);
			if (acc) begin
				dp_addr_r <= haddr[7:0];
				map_ok_r  <= (haddr[31:8] == 24'h000000) && (hsize == rsic_pkg::HSIZE_WORD);
			end
		end
	end

	// sequencer state
	rsic_pkg::rsic_state_t st_r;
	rsic_pkg::rsic_state_t st_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          soft_r;
	logic          soft_nxt;
	wire           run     = (st_r == rsic_pkg::ST_RUN);
	wire           wr_en   = wr_pend_r && map_ok_r && run;
	wire           soft_go = wr_en && (dp_addr_r == rsic_pkg::A_SOFT_RST) && hwdata[0];
	wire           hold    = (st_r == rsic_pkg::ST_HOLD);
	wire [CW-1:0]  rel_lim = soft_r ? CW'(REL_SW_CYC) : CW'(REL_HW_CYC);
	wire [CW-1:0]  ref_lim = soft_nxt ? CW'(REF_SW_CYC) : CW'(REF_HW_CYC);

	// release order: tristate, latch straps, oscillator, pll, logic out of reset
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			rsic_pkg::ST_HOLD:  st_nxt = rsic_pkg::ST_TRI;
			rsic_pkg::ST_TRI:   st_nxt = rsic_pkg::ST_LATCH;
			rsic_pkg::ST_LATCH: st_nxt = rsic_pkg::ST_OSC;
			rsic_pkg::ST_OSC: begin
				if (cnt_r >= CW'(OSC_CYC)) begin
					st_nxt = rsic_pkg::ST_PLL;
				end
			end
			rsic_pkg::ST_PLL: begin
				if (cnt_r >= rel_lim) begin
					st_nxt = rsic_pkg::ST_RUN;
				end
			end
			rsic_pkg::ST_RUN:   st_nxt = rsic_pkg::ST_RUN;
		endcase
		if (soft_go) begin
			st_nxt = rsic_pkg::ST_TRI;
		end
		if (hw_req) begin
			st_nxt = rsic_pkg::ST_HOLD;
		end
	end

	// time since release, saturating
	assign cnt_nxt  = (hw_req || soft_go || hold) ? '0 : (cnt_r != '1 ? cnt_r + CW'(1) : cnt_r);
	assign soft_nxt = hw_req ? 1'b0 : (soft_go ? 1'b1 : soft_r);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r   <= rsic_pkg::ST_HOLD;
			cnt_r  <= '0;
			soft_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			soft_r <= soft_nxt;
		end
	end

	// subsystem reset timers: phy1, phy2, mac
	logic [2:0] tmr_busy_r;
	logic [7:0] tmr_cnt_r [3];
	logic       key_ok_r;
	wire        mac_wr   = wr_en && (dp_addr_r == rsic_pkg::A_MAC_RST);
	wire        key2_wr  = mac_wr && key_ok_r && (hwdata == rsic_pkg::MAC_KEY2);
	wire        blk_wr   = wr_en && (dp_addr_r == rsic_pkg::A_BLK_RST);
	wire [2:0]  tmr_go;
	assign tmr_go[0] = blk_wr && hwdata[0] && !tmr_busy_r[0];
	assign tmr_go[1] = blk_wr && hwdata[1] && !tmr_busy_r[1];
	assign tmr_go[2] = key2_wr && !phy_powered_down[0] && !tmr_busy_r[2];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tmr_busy_r <= 3'h0;
			key_ok_r   <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				tmr_cnt_r[i] <= 8'h00;
			end
		end else begin
			key_ok_r <= hold ? 1'b0 : (mac_wr ? (hwdata == rsic_pkg::MAC_KEY1) : key_ok_r);
			for (int i = 0; i < 3; i++) begin
				if (hold) begin
					tmr_busy_r[i] <= 1'b0;
				end else if (tmr_go[i]) begin
					tmr_busy_r[i] <= 1'b1;
					tmr_cnt_r[i]  <= SUB_M1;
				end else if (tmr_busy_r[i]) begin
					tmr_busy_r[i] <= (tmr_cnt_r[i] != 8'h00);  // self clear
					tmr_cnt_r[i]  <= tmr_cnt_r[i] - 8'h01;
				end
			end
		end
	end

	// event and flag registers
	logic [8:0] stat_a_r;
	logic [8:0] stat_b_r;
	logic [8:0] mask_a_r;
	logic [8:0] mask_b_r;
	logic [3:0] blk_en_r  [2];
	logic [3:0] blk_flg_r [2];
	logic [7:0] sys_en_r  [2];
	logic [7:0] sys_flg_r [2];
	logic [3:0] evt_w [2];
	logic [3:0] err_w [2];
	logic [1:0] phy_irq;
	logic [1:0] clr_phy;
	wire        hw_done = (st_r == rsic_pkg::ST_PLL) && (st_nxt == rsic_pkg::ST_RUN) && !soft_r;
	assign evt_w[0] = phy1_evt;
	assign evt_w[1] = phy2_evt;
	assign err_w[0] = phy1_err;
	assign err_w[1] = phy2_err;
	assign clr_phy  = {hold, hold || soft_go};  // second phy keeps state over soft reset

	// per phy pending: block flags by enable, system flags by system enable except the software flag, which always counts
	for (genvar g = 0; g < 2; g++) begin : g_phy
		wire [7:0] sys_gate = {sys_en_r[g][7:2], 1'b1, sys_en_r[g][rsic_pkg::SYS_HW]};
		assign phy_irq[g] = |(blk_flg_r[g] & blk_en_r[g]) || |(sys_flg_r[g] & sys_gate);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_a_r <= 9'h000;
			stat_b_r <= 9'h000;
			mask_a_r <= rsic_pkg::MASK_RST;
			mask_b_r <= rsic_pkg::MASK_RST;
		end else if (hold || soft_go) begin
			stat_a_r <= 9'h000;
			stat_b_r <= 9'h000;
			mask_a_r <= rsic_pkg::MASK_RST;
			mask_b_r <= rsic_pkg::MASK_RST;
		end else begin
			// write one to clear; a new event in the same cycle wins
			stat_a_r <= (stat_a_r & ~((wr_en && dp_addr_r == rsic_pkg::A_SW_STAT_A) ? hwdata[8:0] : 9'h000))
				| (run ? {phy_irq[0], sw_evt_a} : 9'h000);
			stat_b_r <= (stat_b_r & ~((wr_en && dp_addr_r == rsic_pkg::A_SW_STAT_B) ? hwdata[8:0] : 9'h000))
				| (run ? {phy_irq[1], sw_evt_b} : 9'h000);
			if (wr_en && dp_addr_r == rsic_pkg::A_SW_MASK_A) begin
				mask_a_r <= hwdata[8:0];
			end
			if (wr_en && dp_addr_r == rsic_pkg::A_SW_MASK_B) begin
				mask_b_r <= hwdata[8:0];
			end
		end
	end

	// phy enable and flag registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 2; i++) begin
				blk_en_r[i]  <= rsic_pkg::BLK_EN_RST;
				blk_flg_r[i] <= 4'h0;
				sys_en_r[i]  <= rsic_pkg::SYS_EN_RST;
				sys_flg_r[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (clr_phy[i]) begin
					blk_en_r[i]  <= rsic_pkg::BLK_EN_RST;
					blk_flg_r[i] <= 4'h0;
					sys_en_r[i]  <= rsic_pkg::SYS_EN_RST;
					sys_flg_r[i] <= 8'h00;
				end else begin
					if (wr_en && dp_addr_r == phy_off(i, rsic_pkg::O_BLK_EN)) begin
						blk_en_r[i] <= hwdata[3:0];
					end
					if (wr_en && dp_addr_r == phy_off(i, rsic_pkg::O_SYS_EN)) begin
						sys_en_r[i] <= hwdata[7:0];
					end
					blk_flg_r[i] <= (blk_flg_r[i]
						& ~((wr_en && dp_addr_r == phy_off(i, rsic_pkg::O_BLK_FLG)) ? hwdata[3:0] : 4'h0))
						| (run ? (evt_w[i] & blk_en_r[i]) : 4'h0);
					// error flags clear only by hardware reset, and in the first phy also by soft reset
					sys_flg_r[i] <= (sys_flg_r[i]
						& ~((wr_en && dp_addr_r == phy_off(i, rsic_pkg::O_SYS_FLG)) ? {6'h00, hwdata[1:0]} : 8'h00))
						| {err_w[i], 2'b00, sys_en_r[i][rsic_pkg::SYS_SW] && run,
						   hw_done && sys_en_r[i][rsic_pkg::SYS_HW]};
				end
			end
		end
	end

	// read selection
	wire [1:0]  rdy = {run && !tmr_busy_r[1], run && !tmr_busy_r[0]};
	wire [31:0] rd_phy1 =
		dp_addr_r == phy_off(0, rsic_pkg::O_BLK_EN)  ? {28'h0, blk_en_r[0]} :
		dp_addr_r == phy_off(0, rsic_pkg::O_BLK_FLG) ? {28'h0, blk_flg_r[0]} :
		dp_addr_r == phy_off(0, rsic_pkg::O_SYS_EN)  ? {24'h0, sys_en_r[0]} :
		dp_addr_r == phy_off(0, rsic_pkg::O_SYS_FLG) ? {24'h0, sys_flg_r[0]} :
		dp_addr_r == phy_off(0, rsic_pkg::O_STATE)   ? {30'h0, phy_powered_down[0], rdy[0]} : 32'h0;
	wire [31:0] rd_phy2 =
		dp_addr_r == phy_off(1, rsic_pkg::O_BLK_EN)  ? {28'h0, blk_en_r[1]} :
		dp_addr_r == phy_off(1, rsic_pkg::O_BLK_FLG) ? {28'h0, blk_flg_r[1]} :
		dp_addr_r == phy_off(1, rsic_pkg::O_SYS_EN)  ? {24'h0, sys_en_r[1]} :
		dp_addr_r == phy_off(1, rsic_pkg::O_SYS_FLG) ? {24'h0, sys_flg_r[1]} :
		dp_addr_r == phy_off(1, rsic_pkg::O_STATE)   ? {30'h0, phy_powered_down[1], rdy[1]} : 32'h0;
	wire [31:0] rd_data = !map_ok_r ? 32'h0 :
		dp_addr_r == rsic_pkg::A_SW_STAT_A ? {23'h0, stat_a_r} :
		dp_addr_r == rsic_pkg::A_SW_STAT_B ? {23'h0, stat_b_r} :
		dp_addr_r == rsic_pkg::A_SW_MASK_A ? {23'h0, mask_a_r} :
		dp_addr_r == rsic_pkg::A_SW_MASK_B ? {23'h0, mask_b_r} :
		dp_addr_r == rsic_pkg::A_BLK_RST   ? {30'h0, tmr_busy_r[1:0]} :
		dp_addr_r == rsic_pkg::A_MAC_RST   ? {31'h0, tmr_busy_r[2]} :
		rd_phy1 | rd_phy2;
	wire pend = |(stat_a_r & mask_a_r) || |(stat_b_r & mask_b_r);

	// registered outputs
	logic irq_n_r;
	logic chip_rst_n_r;
	logic io_tristate_r;
	logic cfg_latch_r;
	logic osc_en_r;
	logic pll_en_r;
	logic ref_en_r;
	logic phy1_rst_n_r;
	logic phy2_rst_n_r;
	logic mac_rst_n_r;
	logic tx_abort_r;
	wire  run_nxt = (st_nxt == rsic_pkg::ST_RUN);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r      <= 32'h0;
			irq_n_r       <= 1'b1;
			chip_rst_n_r  <= 1'b0;
			io_tristate_r <= 1'b1;
			cfg_latch_r   <= 1'b0;
			osc_en_r      <= 1'b0;
			pll_en_r      <= 1'b0;
			ref_en_r      <= 1'b0;
			phy1_rst_n_r  <= 1'b0;
			phy2_rst_n_r  <= 1'b0;
			mac_rst_n_r   <= 1'b0;
			tx_abort_r    <= 1'b0;
		end else begin
			if (rd_pend_r) begin
				hrdata_r <= rd_data;
			end
			irq_n_r       <= !pend;
			chip_rst_n_r  <= run_nxt;
			io_tristate_r <= (st_nxt == rsic_pkg::ST_HOLD) || (st_nxt == rsic_pkg::ST_TRI);
			cfg_latch_r   <= (st_nxt == rsic_pkg::ST_LATCH);
			osc_en_r      <= (st_nxt == rsic_pkg::ST_OSC) || (st_nxt == rsic_pkg::ST_PLL) || run_nxt;
			pll_en_r      <= (st_nxt == rsic_pkg::ST_PLL) || run_nxt;
			ref_en_r      <= (st_nxt != rsic_pkg::ST_HOLD) && (cnt_nxt >= ref_lim);
			phy1_rst_n_r  <= run_nxt && !(tmr_go[0] || (tmr_busy_r[0] && tmr_cnt_r[0] != 8'h00));
			phy2_rst_n_r  <= (soft_nxt || run_nxt)
				&& !(tmr_go[1] || (tmr_busy_r[1] && tmr_cnt_r[1] != 8'h00));
			mac_rst_n_r   <= run_nxt && !(tmr_go[2] || (tmr_busy_r[2] && tmr_cnt_r[2] != 8'h00));
			tx_abort_r    <= soft_go;
		end
	end

	assign hreadyout        = hreadyout_r;
	assign hresp            = 1'b0;
	assign hrdata           = hrdata_r;
	assign irq_n            = irq_n_r;
	assign chip_rst_n       = chip_rst_n_r;
	assign io_tristate      = io_tristate_r;
	assign cfg_latch        = cfg_latch_r;
	assign osc_en           = osc_en_r;
	assign pll_en           = pll_en_r;
	assign ref_clock_out_en = ref_en_r;
	assign phy1_rst_n       = phy1_rst_n_r;
	assign phy2_rst_n       = phy2_rst_n_r;
	assign mac_rst_n        = mac_rst_n_r;
	assign tx_abort         = tx_abort_r;

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence rel_steps;
		st_r == rsic_pkg::ST_LATCH ##1 st_r == rsic_pkg::ST_OSC;
	endsequence

	irq_on_event_a: assert property (run && !soft_go && !hw_req && |(sw_evt_a & mask_a_r[7:0])
		##1 (run && $stable(mask_a_r)) |-> ##1 !irq_n_r) else $error("switch event did not raise irq");
	blk_flag_gate_a: assert property ($rose(blk_flg_r[0][0]) |-> $past(blk_en_r[0][0]))
		else $error("phy flag set while disabled");
	hw_irq_latch_a: assert property (hw_done && sys_en_r[0][0] |=> sys_flg_r[0][0])
		else $error("hardware reset interrupt not latched");
	phy_stat_flag_a: assert property (run && phy_irq[0] && !hw_req && !soft_go |=> stat_a_r[8])
		else $error("phy1 flag missing in status");
	sw_irq_latch_a: assert property (run && sys_en_r[0][1] && !hw_req && !soft_go |=> sys_flg_r[0][1])
		else $error("software interrupt not latched");
	err_sticky_a: assert property (sys_flg_r[0][4] && !hold && !soft_go |=> sys_flg_r[0][4])
		else $error("error flag lost without hardware reset");
	power_hold_a: assert property (!pwr_lvl_r |=> hold && !chip_rst_n_r)
		else $error("left reset without power good");
	glitch_rej_a: assert property ($fell(rst_lvl_r) |-> !rst_low_ok [*8])
		else $error("short reset pulse accepted");
	rel_order_a: assert property (st_r == rsic_pkg::ST_TRI && !hw_req && !soft_go |=> rel_steps)
		else $error("release order broken");
	rel_time_a: assert property ($rose(chip_rst_n_r) |-> cnt_r == rel_lim + CW'(1))
		else $error("logic released at wrong time");
	ref_hold_a: assert property ($rose(ref_en_r) |-> cnt_r == ref_lim && !hold)
		else $error("reference clock released at wrong time");
	soft_spare_a: assert property (soft_go && !tmr_busy_r[1] |=> phy2_rst_n_r && !phy1_rst_n_r)
		else $error("soft reset touched second phy");
	tx_abort_a: assert property (soft_go |=> tx_abort_r && !mac_rst_n_r)
		else $error("transmission not aborted");
	blk_len_a: assert property ($rose(tmr_busy_r[0]) |-> tmr_cnt_r[0] == SUB_M1 ##1 !phy1_rst_n_r)
		else $error("phy block reset length wrong");
	mac_pd_a: assert property (key2_wr && phy_powered_down[0] && !tmr_busy_r[2] |=> !tmr_busy_r[2])
		else $error("mac reset ran in power down");
	mac_go_a: assert property (tmr_go[2] && !hw_req |=> !mac_rst_n_r && phy1_rst_n_r == $past(phy1_rst_n_r))
		else $error("mac reset not applied alone");
	irq_release_a: assert property (!pend [*2] |-> irq_n_r)
		else $error("interrupt stuck low");

endmodule

`default_nettype wire
